// ---- verilog/fssq_sequencer.sv ----
// flash self-program sequencer top
`timescale 1ns/1ps
module fssq_sequencer #(
    parameter int WORD_BITS = fssq_pkg::WORD_BITS,
    parameter int PAGE_BITS = fssq_pkg::PAGE_BITS,
    parameter int OP_CYCLES = fssq_pkg::OP_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire logic spm_i,
    input wire logic lpm_i,
    input wire logic [15:0] pointer_i,
    input wire logic [15:0] store_word_i,
    input wire logic [15:0] prog_word_i,
    output logic [7:0] lpm_data_o,
    output logic cpu_halt_o,
    input wire logic eeprom_busy_i,
    input wire logic global_irq_enable_i,
    output logic ready_irq_o,
    input wire logic [7:0] fuse_low_prog_i,
    input wire logic [7:0] fuse_high_prog_i,
    input wire logic [7:0] fuse_ext_prog_i,
    input wire logic [1:0] lock_prog_i,
    output logic flash_erase_o,
    output logic flash_write_o,
    output logic [PAGE_BITS-1:0] flash_page_o,
    output logic flash_wr_valid_o,
    output logic [WORD_BITS-1:0] flash_wr_index_o,
    output logic [15:0] flash_wr_data_o
);
    localparam int WORDS = 1 << WORD_BITS;
    localparam int CW = $clog2(OP_CYCLES + 1);
    localparam logic [CW-1:0] OP_LAST = CW'(OP_CYCLES - 1);

    // control bits
    logic irq_en_reg;
    logic store_en_reg;
    logic erase_reg;
    logic write_reg;
    logic lock_rd_reg;
    logic sect_rd_reg;

    // operation engine
    fssq_pkg::fssq_op_t op_reg;
    fssq_pkg::fssq_op_t op_next;
    logic [CW-1:0] op_count_reg;
    logic [PAGE_BITS-1:0] page_reg;
    logic halt_reg;
    logic erase_out_reg;
    logic write_out_reg;

    // buffer streaming toward the array
    logic stream_reg;
    logic [WORD_BITS-1:0] stream_idx_reg;
    logic wr_valid_reg;
    logic [WORD_BITS-1:0] wr_index_reg;
    logic [15:0] wr_data_reg;

    // read side
    logic [7:0] rdata_reg;
    logic [7:0] lpm_data_reg;
    logic irq_reg;

    // buffer storage
    logic [15:0] buf_data [WORDS];
    logic [WORDS-1:0] buf_loaded;
    logic [WORDS-1:0] buf_load;
    logic buf_clear;

    // decode
    logic ctrl_wr;
    logic [4:0] cmd;
    logic cmd_valid;
    logic op_idle;
    logic accept_cmd;
    logic spm_open;
    logic spm_expire;
    logic lpm_open;
    logic lpm_expire;
    logic spm_take;
    logic load_take;
    logic erase_take;
    logic write_take;
    logic lpm_special;
    logic op_done;
    logic clear_armed;
    logic [WORD_BITS-1:0] word_sel;
    logic [PAGE_BITS-1:0] page_sel;
    logic [7:0] fuse_byte;

    assign ctrl_wr = reg_write_i & (reg_addr_i == fssq_pkg::CTRL_OFFSET);
    assign cmd = reg_wdata_i[4:0];
    assign cmd_valid = (cmd == fssq_pkg::CMD_LOAD) | (cmd == fssq_pkg::CMD_ERASE) |
                       (cmd == fssq_pkg::CMD_WRITE) | (cmd == fssq_pkg::CMD_LOCK_RD) |
                       (cmd == fssq_pkg::CMD_SECT_RD); // [R23]
    assign op_idle = (op_reg == fssq_pkg::FSSQ_OP_IDLE);
    // no arming mid-op or while EEPROM writes
    assign accept_cmd = ctrl_wr & cmd_valid & op_idle & ~eeprom_busy_i; // [R8] [R23]

    // pointer split: bit 0 is the byte, then word, then page
    assign word_sel = pointer_i[WORD_BITS:1]; // [R13] [R19]
    assign page_sel = pointer_i[WORD_BITS+PAGE_BITS:WORD_BITS+1]; // [R13] [R27]

    // any program address may issue a store, no section check
    assign spm_take = spm_i & spm_open & store_en_reg & op_idle & ~eeprom_busy_i; // [R22] [R8]
    assign load_take = spm_take & ~erase_reg & ~write_reg & ~lock_rd_reg & ~sect_rd_reg; // [R2]
    assign erase_take = spm_take & erase_reg; // [R1]
    assign write_take = spm_take & write_reg; // [R3]
    assign lpm_special = lpm_i & lpm_open & lock_rd_reg & store_en_reg & ~eeprom_busy_i; // [R14]
    assign op_done = ~op_idle & (op_count_reg == '0);

    // armed bits drop on window expiry or on any use but erase and write
    assign clear_armed = op_idle & ((spm_take & ~erase_reg & ~write_reg) |
                                    spm_expire | lpm_special | lpm_expire); // [R16]

    fssq_window #(
        .LEN(fssq_pkg::SPM_WINDOW)
    ) u_spm_window (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .enable_i(enable_i),
        .start_i(accept_cmd),
        .stop_i(spm_take | lpm_special),
        .open_o(spm_open),
        .expire_o(spm_expire)
    ); // [R1] [R2] [R3]

    fssq_window #(
        .LEN(fssq_pkg::LPM_WINDOW)
    ) u_lpm_window (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .enable_i(enable_i),
        .start_i(accept_cmd & (cmd == fssq_pkg::CMD_LOCK_RD)),
        .stop_i(lpm_special | spm_take),
        .open_o(lpm_open),
        .expire_o(lpm_expire)
    ); // [R14]

    // control register
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_en_reg <= 1'b0;
            store_en_reg <= 1'b0;
            erase_reg <= 1'b0;
            write_reg <= 1'b0;
            lock_rd_reg <= 1'b0;
            sect_rd_reg <= 1'b0;
        end else if (enable_i) begin
            if (ctrl_wr && op_idle && !eeprom_busy_i) begin
                irq_en_reg <= reg_wdata_i[fssq_pkg::BIT_IRQ_EN];
            end
            if (accept_cmd) begin
                store_en_reg <= 1'b1;
                erase_reg <= cmd[fssq_pkg::BIT_ERASE];
                write_reg <= cmd[fssq_pkg::BIT_WRITE];
                lock_rd_reg <= cmd[fssq_pkg::BIT_LOCK_RD];
                sect_rd_reg <= cmd[fssq_pkg::BIT_SECT_RD];
            end else if (op_done || clear_armed) begin
                // store-enable held high until the timed op ends; a reset still clears it mid-op
                store_en_reg <= 1'b0; // [R24] [R16]
                erase_reg <= 1'b0;
                write_reg <= 1'b0;
                lock_rd_reg <= 1'b0;
                sect_rd_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        op_next = op_reg;
        case (op_reg)
            fssq_pkg::FSSQ_OP_IDLE: begin
                if (erase_take) begin
                    op_next = fssq_pkg::FSSQ_OP_ERASE; // [R1]
                end else if (write_take) begin
                    op_next = fssq_pkg::FSSQ_OP_WRITE; // [R3]
                end
            end
            fssq_pkg::FSSQ_OP_ERASE,
            fssq_pkg::FSSQ_OP_WRITE: begin
                if (op_count_reg == '0) begin
                    op_next = fssq_pkg::FSSQ_OP_IDLE;
                end
            end
            default: begin
                op_next = fssq_pkg::FSSQ_OP_IDLE;
            end
        endcase
    end

    // reset waits for idle: a running op completes
    always_ff @(posedge clock_i) begin
        if (reset_i && op_idle) begin
            op_reg <= fssq_pkg::FSSQ_OP_IDLE; // [R21]
            op_count_reg <= '0;
            page_reg <= '0;
        end else if (enable_i) begin
            op_reg <= op_next;
            if (op_idle) begin
                // calibrated minimum length
                op_count_reg <= OP_LAST; // [R26]
                if (erase_take || write_take) begin
                    // data words ignored, only the page field counts
                    page_reg <= page_sel; // [R1] [R3] [R12]
                end
            end else if (op_count_reg != '0) begin
                op_count_reg <= op_count_reg - CW'(1); // [R26]
            end
        end
    end

    // halt and array strobes straight from flops
    always_ff @(posedge clock_i) begin
        if (reset_i && op_idle) begin
            halt_reg <= 1'b0;
            erase_out_reg <= 1'b0;
            write_out_reg <= 1'b0;
        end else if (enable_i) begin
            halt_reg <= (op_next != fssq_pkg::FSSQ_OP_IDLE); // [R4]
            erase_out_reg <= (op_next == fssq_pkg::FSSQ_OP_ERASE); // [R1]
            write_out_reg <= (op_next == fssq_pkg::FSSQ_OP_WRITE); // [R3]
        end
    end

    // stream the buffer at write start; the stream runs on through a reset,
    // but buffer words not yet sent read back as erased after it
    always_ff @(posedge clock_i) begin
        if (reset_i && op_idle) begin
            stream_reg <= 1'b0;
            stream_idx_reg <= '0;
            wr_valid_reg <= 1'b0;
            wr_index_reg <= '0;
            wr_data_reg <= fssq_pkg::ERASED_WORD;
        end else if (enable_i) begin
            wr_valid_reg <= stream_reg;
            wr_index_reg <= stream_idx_reg;
            wr_data_reg <= buf_data[stream_idx_reg];
            if (write_take) begin
                stream_reg <= 1'b1; // [R3]
                stream_idx_reg <= '0;
            end else if (stream_reg) begin
                stream_idx_reg <= stream_idx_reg + WORD_BITS'(1);
                if (stream_idx_reg == WORD_BITS'(WORDS - 1)) begin
                    stream_reg <= 1'b0;
                end
            end
        end
    end

    // temporary page buffer
    assign buf_clear = (op_done && op_reg == fssq_pkg::FSSQ_OP_WRITE) |
                       (accept_cmd && cmd == fssq_pkg::CMD_SECT_RD) | // [R5]
                       (eeprom_busy_i && (|buf_loaded)); // [R7]

    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_buf
            // any word may be loaded in any order, no sequence enforced
            assign buf_load[gi] = load_take & (word_sel == WORD_BITS'(gi)); // [R2] [R10]
            fssq_buf_word u_word (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .enable_i(enable_i),
                .clear_i(buf_clear),
                .load_i(buf_load[gi]),
                .data_i(store_word_i),
                .data_o(buf_data[gi]),
                .loaded_o(buf_loaded[gi])
            ); // [R5] [R6]
        end
    endgenerate

    // fuse and lock values; inputs mark programmed bits as 1
    always_comb begin
        case (pointer_i)
            fssq_pkg::PTR_FUSE_LOW: fuse_byte = ~fuse_low_prog_i; // [R15] [R18]
            fssq_pkg::PTR_LOCK: fuse_byte = {6'h3f, ~lock_prog_i}; // [R14] [R18]
            fssq_pkg::PTR_FUSE_EXT: fuse_byte = ~fuse_ext_prog_i; // [R15] [R18]
            fssq_pkg::PTR_FUSE_HIGH: fuse_byte = ~fuse_high_prog_i; // [R15] [R18]
            default: fuse_byte = fssq_pkg::LPM_RESET;
        endcase
    end

    // load data one cycle after the load instruction
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            lpm_data_reg <= fssq_pkg::LPM_RESET;
        end else if (enable_i && lpm_i) begin
            if (lpm_special) begin
                lpm_data_reg <= fuse_byte; // [R14] [R15]
            end else if (pointer_i[0]) begin
                lpm_data_reg <= prog_word_i[15:8]; // [R17] [R19]
            end else begin
                lpm_data_reg <= prog_word_i[7:0]; // [R17] [R19]
            end
        end
    end

    // register read port, unmapped offsets read zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_reg <= fssq_pkg::RDATA_RESET;
        end else if (enable_i) begin
            if (reg_read_i && reg_addr_i == fssq_pkg::CTRL_OFFSET) begin
                rdata_reg <= {irq_en_reg, 2'b00, sect_rd_reg, lock_rd_reg,
                              write_reg, erase_reg, store_en_reg}; // [R24]
            end else begin
                rdata_reg <= fssq_pkg::RDATA_RESET;
            end
        end
    end

    // no ready irq during EEPROM write or store
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else if (enable_i) begin
            irq_reg <= irq_en_reg & global_irq_enable_i & ~store_en_reg &
                       ~eeprom_busy_i; // [R25]
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign lpm_data_o = lpm_data_reg;
    assign cpu_halt_o = halt_reg;
    assign ready_irq_o = irq_reg;
    assign flash_erase_o = erase_out_reg;
    assign flash_write_o = write_out_reg;
    assign flash_page_o = page_reg;
    assign flash_wr_valid_o = wr_valid_reg;
    assign flash_wr_index_o = wr_index_reg;
    assign flash_wr_data_o = wr_data_reg;
endmodule // fssq_sequencer

// ---- verilog/fssq_pkg.sv ----
// sequencer constants and types
//
// Notes on behaviour
// (R1) control 00000011 then store within four cycles erases the pointer's page
// (R2) control 00000001 then store within four cycles loads data word into buffer
// (R3) control 00000101 then store within four cycles writes buffer to the page
// (R4) core is stalled for the whole of every page erase and page write
// (R5) buffer clears on write completion, section-read-enable write, and system reset
// (R6) each buffer word may be loaded only once between buffer clears
// (R7) an EEPROM write during buffer loading discards everything loaded so far
// (R8) EEPROM write in progress blocks programming commands and fuse or lock reads
// (R9) software should check the EEPROM busy flag before arming a command
// (R10) buffer words may be loaded in any order within the page
// (R11) erase the page before writing it; buffer fill may precede the erase
// (R12) erase and following write must name the same page; nothing checks it
// (R13) pointer low bits select the word, high bits select the page
// (R14) pointer 0x0001 with lock-read armed returns lock bits within three cycles
// (R15) pointer 0x0000 low, 0x0003 high, 0x0002 extended fuse byte
// (R16) lock-read and store-enable self-clear on read, load timeout, store timeout
// (R17) with lock-read and store-enable clear, load reads program memory normally
// (R18) programmed fuse or lock bits read 0, unprogrammed read 1
// (R19) pointer bit 0 picks the byte on reads; store commands ignore it
// (R20) software should mask interrupts before arming so the window is kept
// (R21) a reset during a flash write lets the write run to its end
// (R22) store commands are accepted from code at any program address
// (R23) any low five bit pattern other than the five commands is ignored
// (R24) store-enable stays set through erase or write, clearing when ready
// (R25) ready interrupt asserts while store-enable clear and both enables set; the code also holds it low during an EEPROM write
// (R26) erase and write are timed from the calibrated clock, 3.7ms to 4.5ms
// (R27) page and word field widths are parameters of the variant

package fssq_pkg;
    localparam int CLK_NS = 25;
    localparam int OP_MIN_NS = 3700000;
    localparam int OP_MAX_NS = 4500000;
    localparam int OP_CYCLES = (OP_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPM_WINDOW = 4;
    localparam int LPM_WINDOW = 3;
    localparam int WORD_BITS = 5;
    localparam int PAGE_BITS = 6;
    localparam int PTR_WIDTH = 16;
    localparam int REG_ADDR_WIDTH = 4;
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] WIN_RESET = 4'h0;
    localparam int BIT_STORE_EN = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WRITE = 2;
    localparam int BIT_LOCK_RD = 3;
    localparam int BIT_SECT_RD = 4;
    localparam int BIT_IRQ_EN = 7;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK_RD = 5'h09;
    localparam logic [4:0] CMD_SECT_RD = 5'h11;
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] LPM_RESET = 8'hff;

    typedef enum logic [1:0] {
        FSSQ_OP_IDLE = 2'b00,
        FSSQ_OP_ERASE = 2'b01,
        FSSQ_OP_WRITE = 2'b10
    } fssq_op_t;
endpackage

// ---- verilog/fssq_window.sv ----
// countdown window open LEN cycles after arming
`timescale 1ns/1ps
module fssq_window #(
    parameter int LEN = 4
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic start_i,
    input wire logic stop_i,
    output logic open_o,
    output logic expire_o
);
    logic [3:0] count_reg;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            count_reg <= fssq_pkg::WIN_RESET;
        end else if (enable_i) begin
            if (start_i) begin
                count_reg <= LEN[3:0];
            end else if (stop_i) begin
                count_reg <= fssq_pkg::WIN_RESET;
            end else if (count_reg != 4'h0) begin
                count_reg <= count_reg - 4'h1;
            end
        end
    end

    assign open_o = (count_reg != 4'h0);
    // last open cycle, nothing taken
    assign expire_o = enable_i & (count_reg == 4'h1) & ~stop_i & ~start_i;
endmodule // fssq_window

// ---- verilog/fssq_buf_word.sv ----
// one word of the temporary page buffer with its loaded mark
`timescale 1ns/1ps
module fssq_buf_word (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic loaded_o
);
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_o <= fssq_pkg::ERASED_WORD; // [R5]
            loaded_o <= 1'b0;
        end else if (enable_i) begin
            if (clear_i) begin
                data_o <= fssq_pkg::ERASED_WORD; // [R5]
                loaded_o <= 1'b0;
            end else if (load_i && !loaded_o) begin
                // a second load before a clear cannot land
                data_o <= data_i; // [R6]
                loaded_o <= 1'b1;
            end
        end
    end
endmodule // fssq_buf_word

// ---- verification/fssq_core_model.sv ----
// processor core model issuing store and load program instructions
`timescale 1ns/1ps
module fssq_core_model (
    input wire logic clock_i,
    input wire logic halt_i,
    output logic spm_o,
    output logic lpm_o,
    output logic [15:0] pointer_o,
    output logic [15:0] store_word_o,
    output logic [15:0] prog_word_o
);
    initial begin
        spm_o = 1'b0;
        lpm_o = 1'b0;
        pointer_o = 16'h0000;
        store_word_o = 16'h0000;
        prog_word_o = 16'hffff;
    end

    // one instruction; program word is pointer ^ a5c3
    task automatic issue(input logic load, input logic [15:0] ptr, input logic [15:0] w);
        @(posedge clock_i);
        while (halt_i === 1'b1) begin
            @(posedge clock_i);
        end
        spm_o <= !load;
        lpm_o <= load;
        pointer_o <= ptr;
        store_word_o <= w;
        prog_word_o <= ptr ^ 16'ha5c3;
        @(posedge clock_i);
        spm_o <= 1'b0;
        lpm_o <= 1'b0;
        // idle buses show the inverse so stale values never match
        pointer_o <= ~ptr;
        store_word_o <= ~w;
        prog_word_o <= ~(ptr ^ 16'ha5c3);
    endtask
endmodule // fssq_core_model

// ---- verification/fssq_sequencer_assertions.sv ----
// checks on the sequencer ports
`timescale 1ns/1ps
module fssq_sequencer_assertions #(
    parameter int OP_CYCLES = fssq_pkg::OP_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic spm_i,
    input wire logic lpm_i,
    input wire logic [15:0] pointer_i,
    input wire logic [7:0] lpm_data_o,
    input wire logic cpu_halt_o,
    input wire logic eeprom_busy_i,
    input wire logic global_irq_enable_i,
    input wire logic ready_irq_o,
    input wire logic [1:0] lock_prog_i,
    input wire logic flash_erase_o,
    input wire logic flash_write_o,
    input wire logic flash_wr_valid_o
);
    logic arm;
    // not reset: the op engine runs on through a reset
    logic [15:0] halt_cnt;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    assign arm = reg_write_i && reg_addr_i == 4'h0 && !eeprom_busy_i && !cpu_halt_o;
    always_ff @(posedge clock_i) begin
        halt_cnt <= cpu_halt_o ? halt_cnt + 16'h1 : 16'h0;
    end
    a_erase_starts: assert property (arm && reg_wdata_i == 8'h03
        ##1 !reg_write_i ##1 spm_i && !eeprom_busy_i |=> flash_erase_o && cpu_halt_o)
        else $error("erase did not start");
    a_write_starts: assert property (arm && reg_wdata_i == 8'h05
        ##1 !reg_write_i ##1 spm_i && !eeprom_busy_i |=> flash_write_o && cpu_halt_o)
        else $error("page write did not start");
    a_halt_length: assert property ($fell(cpu_halt_o) |-> halt_cnt == 16'(OP_CYCLES))
        else $error("halt length wrong");
    a_op_keeps_halt: assert property ((flash_erase_o || flash_write_o) |-> cpu_halt_o)
        else $error("op running without halt");
    a_stream_in_write: assert property (flash_wr_valid_o |-> flash_write_o)
        else $error("buffer stream outside page write");
    a_lock_read_value: assert property (arm && reg_wdata_i == 8'h09
        ##1 !reg_write_i ##1 !lpm_i ##1 lpm_i && !eeprom_busy_i && pointer_i == 16'h0001
        |=> lpm_data_o == {6'h3f, ~lock_prog_i}) else $error("lock read value wrong");
    a_busy_blocks_op: assert property (eeprom_busy_i && !cpu_halt_o |=> !cpu_halt_o)
        else $error("op started during eeprom write");
    a_irq_needs_idle: assert property (ready_irq_o
        |-> $past(global_irq_enable_i) && !$past(cpu_halt_o)) else $error("ready irq early");
    a_store_en_held: assert property (reg_read_i && reg_addr_i == 4'h0 && cpu_halt_o
        ##1 cpu_halt_o |-> reg_rdata_o[0]) else $error("store enable dropped during op");
endmodule // fssq_sequencer_assertions

bind fssq_sequencer fssq_sequencer_assertions #(.OP_CYCLES(OP_CYCLES))
    i_fssq_sequencer_assertions (.*);

// ---- verification/fssq_sequencer_tb.sv ----
// testbench for the flash sequencer
`timescale 1ns/1ps
module fssq_sequencer_tb;
    localparam int OPC = 40;
    localparam logic [7:0] FL = 8'h62;
    localparam logic [7:0] FH = 8'hd9;
    localparam logic [7:0] FE = 8'h05;
    localparam logic [1:0] LK = 2'b10;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic eeprom_busy_i = 1'b0;
    logic global_irq_enable_i = 1'b0;
    logic spm_i, lpm_i, cpu_halt_o, ready_irq_o, flash_erase_o, flash_write_o, flash_wr_valid_o;
    logic [15:0] pointer_i, store_word_i, prog_word_i, flash_wr_data_o;
    logic [7:0] reg_rdata_o, lpm_data_o;
    logic [5:0] flash_page_o;
    logic [4:0] flash_wr_index_o;
    logic [15:0] exp_buf [32], seen [32];
    logic [7:0] fuse_exp [4];
    int error_cnt = 0;
    int samples_checked = 0;

    always #12.5 clock_i = ~clock_i;

    fssq_sequencer #(.OP_CYCLES(OPC)) i_fssq_sequencer (.*, .enable_i(1'b1),
        .fuse_low_prog_i(FL), .fuse_high_prog_i(FH), .fuse_ext_prog_i(FE), .lock_prog_i(LK));

    fssq_core_model i_fssq_core_model (.clock_i(clock_i), .halt_i(cpu_halt_o),
        .spm_o(spm_i), .lpm_o(lpm_i), .pointer_o(pointer_i), .store_word_o(store_word_i),
        .prog_word_o(prog_word_i));

    always @(posedge clock_i) begin
        if (flash_wr_valid_o === 1'b1) begin
            seen[flash_wr_index_o] <= flash_wr_data_o;
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1;
        chk("ctrl", {8'h00, e}, {8'h00, reg_rdata_o});
    endtask

    function automatic logic [7:0] ord(input logic [15:0] p);
        logic [15:0] w;
        w = p ^ 16'ha5c3;
        return p[0] ? w[15:8] : w[7:0];
    endfunction

    task automatic rdp(input logic arm, input logic [15:0] p, input int dly, input logic [7:0] e);
        if (arm) begin
            wr(4'h0, 8'h09);
        end
        repeat (dly) @(posedge clock_i);
        i_fssq_core_model.issue(1'b1, p, 16'h0000);
        #1;
        chk("lpm", {8'h00, e}, {8'h00, lpm_data_o});
    endtask

    // dly 2: last window cycle; 3: past it
    task automatic ld(input logic [4:0] i, input logic [15:0] w, input logic b0, input int dly,
            input logic upd);
        wr(4'h0, 8'h01);
        repeat (dly) @(posedge clock_i);
        i_fssq_core_model.issue(1'b0, {4'h0, 6'h15, i, b0}, w);
        if (upd) begin
            exp_buf[i] = w;
        end
    endtask

    task automatic op(input logic [7:0] cmd, input logic [5:0] pg, input int rst_at);
        int n;
        n = 0;
        for (int i = 0; i < 32; i++) seen[i] = 16'h0000;
        wr(4'h0, cmd);
        i_fssq_core_model.issue(1'b0, {4'h0, pg, (cmd == 8'h05) ? 6'h00 : 6'h3f}, 16'h7777);
        do begin
            @(posedge clock_i);
            reg_read_i <= (n == 4);
            reset_i <= (n == rst_at);
            #1;
            if (n == 0) begin
                chk("page", {10'h000, pg}, {10'h000, flash_page_o});
                chk1("erase", cmd == 8'h03, flash_erase_o);
                chk1("write", cmd == 8'h05, flash_write_o);
            end
            if (n == 5) begin
                chk1("store_en", 1'b1, reg_rdata_o[0]);
            end
            n++;
        end while (cpu_halt_o === 1'b1 && n < 200);
        chk("halt", 16'(OPC), 16'(n));
        rd(4'h0, 8'h00);
        for (int i = 0; i < 32 && cmd == 8'h05; i++) begin
            chk("stream", exp_buf[i], seen[i]);
            exp_buf[i] = 16'hffff;
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        complete_run;
    end

    initial begin
        for (int i = 0; i < 32; i++) exp_buf[i] = 16'hffff;
        fuse_exp = '{~FL, {6'h3f, ~LK}, ~FE, ~FH};
        repeat (20) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h5, 8'h00);
        rdp(1'b0, 16'h0123, 0, ord(16'h0123));
        rdp(1'b0, 16'h0122, 0, ord(16'h0122));
        for (int p = 0; p < 4; p++) begin
            rdp(1'b1, 16'(p), 1, fuse_exp[p]);
        end
        rdp(1'b1, 16'h0001, 2, ord(16'h0001));
        ld(5'h07, 16'h1234, 1'b0, 0, 1'b1);
        ld(5'h02, 16'hbeef, 1'b1, 0, 1'b1);
        ld(5'h07, 16'h0bad, 1'b0, 0, 1'b0);
        ld(5'h1f, 16'h4321, 1'b0, 2, 1'b1);
        ld(5'h00, 16'h9999, 1'b0, 3, 1'b0);
        rd(4'h0, 8'h00);
        op(8'h05, 6'h2a, -1);
        ld(5'h04, 16'h5555, 1'b0, 0, 1'b1);
        op(8'h03, 6'h09, -1);
        op(8'h05, 6'h09, -1);
        ld(5'h09, 16'h7e7e, 1'b0, 0, 1'b0);
        @(posedge clock_i);
        eeprom_busy_i <= 1'b1;
        ld(5'h06, 16'h6666, 1'b0, 0, 1'b0);
        rd(4'h0, 8'h00);
        rdp(1'b1, 16'h0000, 0, ord(16'h0000));
        @(posedge clock_i);
        eeprom_busy_i <= 1'b0;
        op(8'h05, 6'h01, -1);
        ld(5'h03, 16'h3333, 1'b0, 0, 1'b0);
        wr(4'h0, 8'h11);
        op(8'h05, 6'h02, -1);
        op(8'h05, 6'h11, 12);
        wr(4'h0, 8'h87);
        rd(4'h0, 8'h80);
        @(posedge clock_i);
        global_irq_enable_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        chk1("irq", 1'b1, ready_irq_o);
        wr(4'h0, 8'h81);
        @(posedge clock_i);
        #1;
        chk1("irq", 1'b0, ready_irq_o);
        complete_run;
    end
endmodule // fssq_sequencer_tb
